// ==== bench/line_partner.sv ====
// Purpose: far side of the two channel lines
// Assumes: the bench sets each line's outside level
// Notes: a driven line shows the channel's level
`timescale 1ns/1ps
module line_partner (
  input  wire logic a_out,
  input  wire logic a_oe,
  input  wire logic b_out,
  input  wire logic b_oe,
  input  wire logic a_ext,
  input  wire logic b_ext,
  output logic      a_in,
  output logic      b_in
);
  // released line shows the outside level
  assign a_in = a_oe ? a_out : a_ext;
  assign b_in = b_oe ? b_out : b_ext;
endmodule

// ==== bench/timer_channel_checker.sv ====
// Purpose: port-level channel assertions
// Assumes: one-cycle register strobes
// Notes: a protect shadow gates mode readback
`timescale 1ns/1ps
module timer_channel_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        channel_line_a_out,
  input wire logic        channel_line_a_oe,
  input wire logic        channel_line_b_out,
  input wire logic        channel_line_b_oe
);
  logic prot_q;
  // protect bit shadow, bus side only
  always_ff @(posedge clk_sys) begin
    if (rst) prot_q <= 1'b0;
    else if (reg_wr && reg_addr == 8'he4) prot_q <= reg_wdata[0];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence mode_wr_s; reg_wr && reg_addr == 8'h04 && !prot_q; endsequence
  sequence mode_rd_s; reg_rd && reg_addr == 8'h04; endsequence
  sequence prot_wr_s; reg_wr && reg_addr == 8'he4; endsequence
  sequence prot_rd_s; reg_rd && reg_addr == 8'he4; endsequence
  // bus and reset framing
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("rdata not idle");
  reset_state_a: assert property (disable iff (1'b0) rst |=>
    !channel_line_a_oe && !channel_line_b_oe && !channel_line_a_out)
    else $error("reset outputs");
  // line direction, status and readback
  b_needs_a_a: assert property (channel_line_b_oe |-> channel_line_a_oe)
    else $error("b driven in capture");
  b_input_quiet_a: assert property (!channel_line_b_oe &&
    $past(!channel_line_b_oe) |-> $stable(channel_line_b_out))
    else $error("b moved as input");
  oe_cause_a: assert property ($changed(channel_line_a_oe) |->
    $past(reg_wr) || $past(reg_wr, 2))
    else $error("a dir without write");
  status_mirror_a: assert property (reg_rd && reg_addr == 8'h20 |=>
    reg_rdata[17] == $past(channel_line_a_out))
    else $error("status a mismatch");
  prot_back_a: assert property (prot_wr_s ##1 prot_rd_s |=>
    reg_rdata[0] == $past(reg_wdata[0], 2))
    else $error("protect readback");
  mode_back_a: assert property (mode_wr_s ##1 mode_rd_s |=>
    reg_rdata == $past(reg_wdata, 2))
    else $error("mode write lost");
endmodule
bind timer_channel timer_channel_checker watch (.clk_sys, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .channel_line_a_out,
  .channel_line_a_oe, .channel_line_b_out, .channel_line_b_oe);

// ==== bench/timer_channel_waveform_mode_config_test.sv ====
// Purpose: self-checking channel bench
// Assumes: WIDTH 4 keeps periods short
// Notes: lines judged at pins, counts via registers
`timescale 1ns/1ps
module timer_channel_waveform_mode_config_test;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic        prog = 1'b0;
  logic        slow = 1'b0;
  logic [2:0]  ext = 3'h0;
  logic        a_ext = 1'b0;
  logic        b_ext = 1'b0;
  logic        a_in, a_out, a_oe, b_in, b_out, b_oe, ea, eb;
  int          n_fail = 0;
  int          comparisons = 0;
  int          n, k;
  int          per[5] = '{5, 8, 32, 128, 15};
  logic [7:0]  ad[5] = '{8'h04, 8'h10, 8'h20, 8'he4, 8'h08};
  // free-running sources
  always #4 clk_sys = ~clk_sys;
  always #20 prog = ~prog;
  always #60 slow = ~slow;
  timer_channel #(.WIDTH(4)) dut (.clk_sys, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .programmable_clock_6(prog),
    .slow_clock(slow), .external_clock_line_0(ext[0]),
    .external_clock_line_1(ext[1]), .external_clock_line_2(ext[2]),
    .channel_line_a_in(a_in), .channel_line_a_out(a_out),
    .channel_line_a_oe(a_oe), .channel_line_b_in(b_in),
    .channel_line_b_out(b_out), .channel_line_b_oe(b_oe));
  line_partner far (.a_out, .a_oe, .b_out, .b_oe, .a_ext, .b_ext, .a_in,
    .b_in);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle strobes
  task wr(input logic [7:0] a, input logic [31:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task px(input logic v);
    ext[0] <= v;
    a_ext <= v;
    cyc(8);
  endtask
  function logic ln(input bit s);
    return s ? b_out : a_out;
  endfunction
  function logic act(input logic v, input logic [1:0] c);
    return c == 2'h0 ? v : c == 2'h1 ? 1'b1 : c == 2'h2 ? 1'b0 : !v;
  endfunction
  // cycles until the line changes; bounded so a dead line cannot hang
  task tw(input bit s, output int c);
    logic v;
    #1 v = ln(s);
    c = 0;
    while (ln(s) === v && c < 400) begin
      @(posedge clk_sys);
      #1 c++;
    end
  endtask
  task t_reset();
    for (k = 0; k < 5; k++) begin
      rd(ad[k]);
      chk("reset", 32'h0, d);
    end
  endtask
  task t_protect();
    wr(8'he4, 32'h1);
    rd(8'he4);
    wr(8'h04, 32'h0000_8403);
    rd(8'h04);
    chk("locked", 32'h0, d);
    wr(8'he4, 32'h0);
    wr(8'h04, 32'hffff_8403);
    rd(8'h04);
    chk("open", 32'hffff_8403, d);
  endtask
  task t_soft();
    for (k = 1; k < 4; k++) begin
      wr(8'h04, {k[1:0], 6'h0, k[1:0], 6'h0, 16'h8403});
      ea = act(a_out, k[1:0]);
      eb = act(b_out, k[1:0]);
      wr(8'h00, 32'h5);
      rd(8'h10);
      chk("trig count", 32'h1, 32'(d < 32'h2));
      cyc(3);
      chk("soft a", 32'(ea), 32'(a_out));
      chk("soft b", 32'(eb), 32'(b_out));
    end
    rd(8'h20);
    chk("clk on", 32'h1, 32'(d[16]));
  endtask
  // toggle on C; two periods show the turn points
  task t_period(input logic [1:0] sh, input int e);
    wr(8'h1c, 32'h3);
    wr(8'h04, {16'h000c, 1'b1, sh, 13'h0401});
    wr(8'h00, 32'h5);
    tw(0, n);
    tw(0, k);
    tw(0, n);
    chk("period", 32'(e), 32'(n + k));
  endtask
  task t_match();
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h2);
    wr(8'h04, 32'h0909_c401);
    wr(8'h00, 32'h5);
    for (k = 0; k < 2; k++) begin
      tw(k[0], n);
      if (ln(k[0]) !== 1'b1) tw(k[0], n);
      tw(k[0], n);
      chk("high", 32'(16 - 8 * k), 32'(n));
    end
  endtask
  task t_stop();
    wr(8'h04, 32'h0000_8441);
    wr(8'h00, 32'h5);
    cyc(150);
    rd(8'h10);
    chk("stop count", 32'h3, d);
    rd(8'h20);
    chk("stop en", 32'h1, 32'(d[16]));
    wr(8'h04, 32'h0000_8481);
    wr(8'h00, 32'h5);
    cyc(150);
    rd(8'h20);
    chk("disabled", 32'h0, 32'(d[16]));
    wr(8'h00, 32'h4);
    cyc(150);
    rd(8'h10);
    chk("trig only", 32'h0, d);
    wr(8'h00, 32'h1);
    cyc(20);
    rd(8'h10);
    chk("resume", 32'h1, 32'(d != 32'h0));
  endtask
  // five source periods give four to six ticks
  task t_clk();
    for (k = 0; k < 5; k++) begin
      wr(8'h04, {16'h0, 13'h1000, k[2:0]});
      wr(8'h00, 32'h5);
      cyc(5 * per[k]);
      rd(8'h10);
      chk("ticks", 32'h1, 32'(d >= 32'h4 && d <= 32'h6));
    end
  endtask
  task t_ext();
    for (k = 0; k < 2; k++) begin
      wr(8'h04, {16'h0, 12'h800, k[0], 3'h5});
      wr(8'h00, 32'h5);
      px(1'b1);
      rd(8'h10);
      chk("rise", 32'(k == 0), d);
      px(1'b0);
      rd(8'h10);
      chk("fall", 32'h1, d);
    end
    wr(8'h04, 32'h0000_8021);
    wr(8'h00, 32'h5);
    cyc(80);
    rd(8'h10);
    chk("gated", 32'h0, d);
    ext[1] <= 1'b1;
    cyc(40);
    rd(8'h10);
    chk("ungated", 32'h1, 32'(d != 32'h0));
    ext[1] <= 1'b0;
  endtask
  task t_event();
    for (k = 0; k < 4; k++) begin
      wr(8'h04, {16'h2030, 6'h21, k[1:0], 8'h03});
      ea = a_out;
      eb = b_out;
      px(1'b1);
      chk("ev rise", 32'(ea ^ k[0]), 32'(a_out));
      px(1'b0);
      chk("ev fall", 32'(ea ^ k[0] ^ k[1]), 32'(a_out));
      chk("ev b", 32'(k == 0 ? eb : 1'b0), 32'(b_out));
    end
    wr(8'h04, 32'h0030_9101);
    wr(8'h00, 32'h1);
    cyc(20);
    ea = a_out;
    b_ext <= 1'b1;
    cyc(5);
    rd(8'h10);
    chk("ev restart", 32'h1, 32'(d < 32'h2));
    chk("b released", 32'h0, 32'(b_oe));
    chk("b ev on a", 32'(!ea), 32'(a_out));
  endtask
  task t_capture();
    wr(8'h04, 32'h0011_0000);
    wr(8'h00, 32'h6);
    for (k = 0; k < 2; k++) begin
      px(1'b1);
      px(1'b0);
      rd(8'h14);
      chk("capture a", 32'(1 - k), d);
    end
  endtask
  task results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    cyc(20);
    rst <= 1'b0;
    t_reset();
    t_protect();
    t_soft();
    t_period(2'h0, 256);
    t_period(2'h1, 240);
    t_period(2'h2, 64);
    t_period(2'h3, 96);
    t_match();
    t_stop();
    t_clk();
    t_ext();
    t_event();
    t_capture();
    results();
  end
  // run needs well under this
  initial begin
    #100000;
    n_fail++;
    results();
  end
endmodule

// ==== pkg/timer_channel_pkg.sv ====
// Purpose: constants for one waveform/capture timer channel
// Assumes: 32-bit register port
// Notes: fields index the channel mode register
//
// Behaviour
// - capture loads every 1/2/4/8/16 selected edges
// - mode writes ignored while write protect set
// - clock select: prog, mck/8/32/128, slow, ext 0-2
// - invert bit picks falling clock edge
// - gate code ANDs external line with clock
// - stop bit halts clock on C match
// - disable bit disables clock on C match
// - event edge: none, rising, falling, both
// - event source: line B or external lines
// - line B as event source becomes input
// - enabled event resets counter, restarts a stopped clock
// - events act on output lines, except in a cycle with a software trigger
// - shape: up, up-down, each with auto trigger
// - wave bit picks waveform or capture layout
// - A match acts on line A
// - C match acts on line A
// - external event acts on line A
// - software trigger acts on line A
// - B match acts on line B
// - C match acts on line B
// - external event acts on line B
// - software trigger acts on line B
// - software trigger resets counter, restarts a stopped clock
package timer_channel_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODE    = 8'h04;
  localparam logic [7:0] OFF_COUNT   = 8'h10;
  localparam logic [7:0] OFF_CMP_A   = 8'h14;
  localparam logic [7:0] OFF_CMP_B   = 8'h18;
  localparam logic [7:0] OFF_CMP_C   = 8'h1c;
  localparam logic [7:0] OFF_STATUS  = 8'h20;
  localparam logic [7:0] OFF_PROTECT = 8'he4;
  // channel control command bits
  localparam int CTL_CLK_ENABLE  = 0;
  localparam int CTL_CLK_DISABLE = 1;
  localparam int CTL_SOFT_TRIG   = 2;
  // status and protect bits
  localparam int STA_CLK_ENABLED = 16;
  localparam int STA_LINE_A      = 17;
  localparam int STA_LINE_B      = 18;
  localparam int PROT_ENABLE     = 0;
  // mode fields of both layouts
  localparam int F_CLK_SEL    = 0;
  localparam int F_CLK_INVERT = 3;
  localparam int F_GATE_SEL   = 4;
  localparam int F_WAVE       = 15;
  // waveform layout
  localparam int F_STOP_C     = 6;
  localparam int F_DIS_C      = 7;
  localparam int F_EV_EDGE    = 8;
  localparam int F_EV_SRC     = 10;
  localparam int F_EV_TRIG    = 12;
  localparam int F_SHAPE      = 13;
  localparam int F_A_ON_A     = 16;
  localparam int F_A_ON_C     = 18;
  localparam int F_A_ON_EV    = 20;
  localparam int F_A_ON_SW    = 22;
  localparam int F_B_ON_B     = 24;
  localparam int F_B_ON_C     = 26;
  localparam int F_B_ON_EV    = 28;
  localparam int F_B_ON_SW    = 30;
  // capture layout
  localparam int F_LOAD_A_EDGE = 16;
  localparam int F_LOAD_B_EDGE = 18;
  localparam int F_SUBSAMPLE   = 20;
  localparam logic [2:0] SUBSAMPLE_MAX = 3'h4;
  // clock source codes
  localparam logic [2:0] CLK_PROG   = 3'h0;
  localparam logic [2:0] CLK_DIV8   = 3'h1;
  localparam logic [2:0] CLK_DIV32  = 3'h2;
  localparam logic [2:0] CLK_DIV128 = 3'h3;
  localparam logic [2:0] CLK_SLOW   = 3'h4;
  localparam logic [2:0] CLK_EXT0   = 3'h5;
  // divider bit giving each divided clock
  localparam int DIV_W        = 7;
  localparam int DIV8_BIT     = 2;
  localparam int DIV32_BIT    = 4;
  localparam int DIV128_BIT   = 6;
  // synchroniser slots
  localparam int PIN_N     = 7;
  localparam int PIN_PROG  = 0;
  localparam int PIN_SLOW  = 1;
  localparam int PIN_EXT0  = 2;
  localparam int PIN_LA    = 5;
  localparam int PIN_LB    = 6;
  // edge codes and output actions
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] ACT_SET    = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // event source that makes line B an input
  localparam logic [1:0] EV_FROM_LINE_B = 2'h0;
  typedef enum logic [1:0] {
    SHAPE_UP, SHAPE_UPDOWN, SHAPE_UP_AUTO, SHAPE_UPDOWN_AUTO
  } shape_t;
endpackage

// ==== rtl/timer_channel.sv ====
// Purpose: one timer channel, waveform and capture operation
// Assumes: clk_sys is the master clock; pins are asynchronous
// Notes: all state is one struct
`timescale 1ns/1ps
module timer_channel #(
  parameter int WIDTH = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              programmable_clock_6,
  input  wire logic              slow_clock,
  input  wire logic              external_clock_line_0,
  input  wire logic              external_clock_line_1,
  input  wire logic              external_clock_line_2,
  input  wire logic              channel_line_a_in,
  output logic                   channel_line_a_out,
  output logic                   channel_line_a_oe,
  input  wire logic              channel_line_b_in,
  output logic                   channel_line_b_out,
  output logic                   channel_line_b_oe
);

  // refuse widths the port cannot carry
  if (WIDTH < 2 || WIDTH > 32) begin : g_width_check
    $error("timer_channel: WIDTH must lie in 2..32");
  end

  typedef struct packed {
    logic [31:0]                       mode;
    logic                              protect;
    logic [WIDTH-1:0]                  cmp_a;
    logic [WIDTH-1:0]                  cmp_b;
    logic [WIDTH-1:0]                  cmp_c;
    logic [WIDTH-1:0]                  count;
    logic                              count_down;
    logic                              clk_enabled;
    logic                              clk_stopped;
    logic                              line_a;
    logic                              line_b;
    logic                              oe_a;
    logic                              oe_b;
    logic [timer_channel_pkg::DIV_W-1:0] div;
    logic [timer_channel_pkg::PIN_N-1:0] sync1;
    logic [timer_channel_pkg::PIN_N-1:0] sync2;
    logic [timer_channel_pkg::PIN_N-1:0] sync3;
    logic [timer_channel_pkg::PIN_N-1:0] pin;
    logic [timer_channel_pkg::PIN_N-1:0] pin_prev;
    logic                              src_prev;
    logic [3:0]                        sub_count;
    logic [31:0]                       rdata;
  } state_t;

  state_t state;
  state_t next_state;

  // one output action applied to a line level
  function automatic logic apply_action(input logic level,
                                        input logic [1:0] code);
    logic result;
    result = level;
    case (code)
      timer_channel_pkg::ACT_SET:    result = 1'b1;
      timer_channel_pkg::ACT_CLEAR:  result = 1'b0;
      timer_channel_pkg::ACT_TOGGLE: result = ~level;
      default:                       result = level;
    endcase
    return result;
  endfunction

  // edge match of a level pair against a two-bit edge code
  function automatic logic edge_hit(input logic now, input logic was,
                                    input logic [1:0] code);
    logic rise;
    logic fall;
    rise = now & ~was;
    fall = ~now & was;
    case (code)
      timer_channel_pkg::EDGE_RISE: edge_hit = rise;
      timer_channel_pkg::EDGE_FALL: edge_hit = fall;
      timer_channel_pkg::EDGE_BOTH: edge_hit = rise | fall;
      default:                      edge_hit = 1'b0;
    endcase
  endfunction

  logic [timer_channel_pkg::PIN_N-1:0] pins_raw;
  assign pins_raw = {channel_line_b_in, channel_line_a_in,
                     external_clock_line_2, external_clock_line_1,
                     external_clock_line_0, slow_clock,
                     programmable_clock_6};

  always_comb begin
    logic                 wave;
    logic [2:0]           clk_sel;
    logic [1:0]           gate_sel;
    logic [1:0]           ev_src;
    logic                 src_level;
    logic                 src_edge;
    logic                 gate_ok;
    logic                 tick;
    logic                 ev_now;
    logic                 ev_was;
    logic                 ev_hit;
    logic                 sw_trig;
    logic                 trig;
    logic                 b_is_output;
    logic                 a_hit;
    logic                 b_hit;
    logic                 c_hit;
    logic [1:0]           act_a;
    logic [1:0]           act_b;
    logic [WIDTH-1:0]     top;
    logic                 ld_a;
    logic                 ld_b;
    logic [3:0]           sub_last;
    logic [2:0]           sub_code;
    timer_channel_pkg::shape_t shape;
    wave        = 1'b0;
    clk_sel     = 3'h0;
    gate_sel    = 2'h0;
    ev_src      = 2'h0;
    src_level   = 1'b0;
    src_edge    = 1'b0;
    gate_ok     = 1'b0;
    tick        = 1'b0;
    ev_now      = 1'b0;
    ev_was      = 1'b0;
    ev_hit      = 1'b0;
    sw_trig     = 1'b0;
    trig        = 1'b0;
    b_is_output = 1'b0;
    a_hit       = 1'b0;
    b_hit       = 1'b0;
    c_hit       = 1'b0;
    act_a       = 2'h0;
    act_b       = 2'h0;
    top         = '1;
    ld_a        = 1'b0;
    ld_b        = 1'b0;
    sub_last    = 4'h0;
    sub_code    = 3'h0;
    shape       = timer_channel_pkg::SHAPE_UP;
    next_state  = state;

    // three-flop pin sync; stages 2 and 3 must agree
    next_state.sync1    = pins_raw;
    next_state.sync2    = state.sync1;
    next_state.sync3    = state.sync2;
    for (int i = 0; i < timer_channel_pkg::PIN_N; i++) begin
      if (state.sync2[i] == state.sync3[i]) begin
        next_state.pin[i] = state.sync3[i];
      end
    end
    next_state.pin_prev = state.pin;
    next_state.div      = state.div + 7'h01;

    wave     = state.mode[timer_channel_pkg::F_WAVE];
    clk_sel  = state.mode[timer_channel_pkg::F_CLK_SEL +: 3];
    gate_sel = state.mode[timer_channel_pkg::F_GATE_SEL +: 2];
    ev_src   = state.mode[timer_channel_pkg::F_EV_SRC +: 2];
    if (wave) begin
      shape = timer_channel_pkg::shape_t'(
                state.mode[timer_channel_pkg::F_SHAPE +: 2]);
    end

    // divided master clocks are plain levels, so all sources share one
    // edge detector; a select change may yield one spurious edge
    case (clk_sel)
      timer_channel_pkg::CLK_PROG:
        src_level = state.pin[timer_channel_pkg::PIN_PROG];
      timer_channel_pkg::CLK_DIV8:
        src_level = state.div[timer_channel_pkg::DIV8_BIT];
      timer_channel_pkg::CLK_DIV32:
        src_level = state.div[timer_channel_pkg::DIV32_BIT];
      timer_channel_pkg::CLK_DIV128:
        src_level = state.div[timer_channel_pkg::DIV128_BIT];
      timer_channel_pkg::CLK_SLOW:
        src_level = state.pin[timer_channel_pkg::PIN_SLOW];
      default:
        src_level = state.pin[timer_channel_pkg::PIN_EXT0 +
                    int'(clk_sel - timer_channel_pkg::CLK_EXT0)];
    endcase
    // invert counts falling edges
    src_level = src_level ^
                state.mode[timer_channel_pkg::F_CLK_INVERT];
    src_edge  = src_level & ~state.src_prev;
    next_state.src_prev = src_level;

    // gate sampled beside the clock edge
    gate_ok = (gate_sel == 2'h0) ||
              state.pin[timer_channel_pkg::PIN_EXT0 +
                        int'(gate_sel) - 1];
    tick = src_edge & gate_ok & state.clk_enabled & ~state.clk_stopped;

    // external event, waveform only
    if (ev_src == timer_channel_pkg::EV_FROM_LINE_B) begin
      ev_now = state.pin[timer_channel_pkg::PIN_LB];
      ev_was = state.pin_prev[timer_channel_pkg::PIN_LB];
    end else begin
      ev_now = state.pin[timer_channel_pkg::PIN_EXT0 +
                         int'(ev_src) - 1];
      ev_was = state.pin_prev[timer_channel_pkg::PIN_EXT0 +
                              int'(ev_src) - 1];
    end
    ev_hit = wave & edge_hit(ev_now, ev_was,
               state.mode[timer_channel_pkg::F_EV_EDGE +: 2]);
    b_is_output = wave &
                  (ev_src != timer_channel_pkg::EV_FROM_LINE_B);

    sw_trig = reg_wr && reg_addr == timer_channel_pkg::OFF_CONTROL &&
              reg_wdata[timer_channel_pkg::CTL_SOFT_TRIG];
    trig = sw_trig |
           (ev_hit & state.mode[timer_channel_pkg::F_EV_TRIG]);

    // top is C in the auto-trigger shapes
    if (shape == timer_channel_pkg::SHAPE_UP_AUTO ||
        shape == timer_channel_pkg::SHAPE_UPDOWN_AUTO) begin
      top = state.cmp_c;
    end
    if (trig) begin
      next_state.count       = '0;
      next_state.count_down  = 1'b0;
      next_state.clk_stopped = 1'b0;
    end else if (tick) begin
      unique case (shape)
        timer_channel_pkg::SHAPE_UP: begin
          next_state.count = state.count + WIDTH'(1);
        end
        timer_channel_pkg::SHAPE_UP_AUTO: begin
          if (state.count == top) begin
            next_state.count = '0;
          end else begin
            next_state.count = state.count + WIDTH'(1);
          end
        end
        timer_channel_pkg::SHAPE_UPDOWN,
        timer_channel_pkg::SHAPE_UPDOWN_AUTO: begin
          if (!state.count_down) begin
            if (state.count == top) begin
              next_state.count_down = 1'b1;
              next_state.count      = state.count - WIDTH'(1);
            end else begin
              next_state.count = state.count + WIDTH'(1);
            end
          end else if (state.count == '0) begin
            next_state.count_down = 1'b0;
            next_state.count      = WIDTH'(1);
          end else begin
            next_state.count = state.count - WIDTH'(1);
          end
        end
      endcase
      a_hit = wave && next_state.count == state.cmp_a;
      b_hit = wave && next_state.count == state.cmp_b;
      c_hit = wave && next_state.count == state.cmp_c;
    end

    // C match stops or disables the counter clock
    if (c_hit && state.mode[timer_channel_pkg::F_STOP_C]) begin
      next_state.clk_stopped = 1'b1;
    end
    if (c_hit && state.mode[timer_channel_pkg::F_DIS_C]) begin
      next_state.clk_enabled = 1'b0;
    end

    // line actions, one per line per cycle, highest source wins
    if (sw_trig) begin
      act_a = state.mode[timer_channel_pkg::F_A_ON_SW +: 2];
      act_b = state.mode[timer_channel_pkg::F_B_ON_SW +: 2];
    end else if (ev_hit) begin
      act_a = state.mode[timer_channel_pkg::F_A_ON_EV +: 2];
      act_b = state.mode[timer_channel_pkg::F_B_ON_EV +: 2];
    end else if (c_hit) begin
      act_a = state.mode[timer_channel_pkg::F_A_ON_C +: 2];
      act_b = state.mode[timer_channel_pkg::F_B_ON_C +: 2];
    end else begin
      if (a_hit) begin
        act_a = state.mode[timer_channel_pkg::F_A_ON_A +: 2];
      end
      if (b_hit) begin
        act_b = state.mode[timer_channel_pkg::F_B_ON_B +: 2];
      end
    end
    if (wave) begin
      next_state.line_a = apply_action(state.line_a, act_a);
    end
    if (b_is_output) begin
      next_state.line_b = apply_action(state.line_b, act_b);
    end
    next_state.oe_a = wave;
    next_state.oe_b = b_is_output;

    // capture loads on line A edges, thinned by the ratio
    if (!wave) begin
      ld_a = edge_hit(state.pin[timer_channel_pkg::PIN_LA],
               state.pin_prev[timer_channel_pkg::PIN_LA],
               state.mode[timer_channel_pkg::F_LOAD_A_EDGE +: 2]);
      ld_b = edge_hit(state.pin[timer_channel_pkg::PIN_LA],
               state.pin_prev[timer_channel_pkg::PIN_LA],
               state.mode[timer_channel_pkg::F_LOAD_B_EDGE +: 2]);
      sub_code = state.mode[timer_channel_pkg::F_SUBSAMPLE +: 3];
      // codes above the largest ratio act as the largest
      if (sub_code > timer_channel_pkg::SUBSAMPLE_MAX) begin
        sub_code = timer_channel_pkg::SUBSAMPLE_MAX;
      end
      sub_last = 4'((5'h01 << sub_code) - 5'h01);
      if (ld_a || ld_b) begin
        if (state.sub_count >= sub_last) begin
          next_state.sub_count = 4'h0;
          if (ld_a) begin
            next_state.cmp_a = state.count;
          end
          if (ld_b) begin
            next_state.cmp_b = state.count;
          end
        end else begin
          next_state.sub_count = state.sub_count + 4'h1;
        end
      end
    end

    // register writes; protected ones drop silently
    if (reg_wr) begin
      case (reg_addr)
        timer_channel_pkg::OFF_CONTROL: begin
          // disable command beats enable in the same write
          if (reg_wdata[timer_channel_pkg::CTL_CLK_DISABLE]) begin
            next_state.clk_enabled = 1'b0;
          end else if (reg_wdata[timer_channel_pkg::CTL_CLK_ENABLE]) begin
            next_state.clk_enabled = 1'b1;
          end
        end
        timer_channel_pkg::OFF_MODE: begin
          if (!state.protect) begin
            next_state.mode = reg_wdata;
          end
        end
        timer_channel_pkg::OFF_CMP_A: begin
          if (!state.protect && wave) begin
            next_state.cmp_a = reg_wdata[WIDTH-1:0];
          end
        end
        timer_channel_pkg::OFF_CMP_B: begin
          if (!state.protect && wave) begin
            next_state.cmp_b = reg_wdata[WIDTH-1:0];
          end
        end
        timer_channel_pkg::OFF_CMP_C: begin
          if (!state.protect) begin
            next_state.cmp_c = reg_wdata[WIDTH-1:0];
          end
        end
        timer_channel_pkg::OFF_PROTECT: begin
          next_state.protect = reg_wdata[timer_channel_pkg::PROT_ENABLE];
        end
        default: begin
        end
      endcase
    end

    // read data stands for exactly the cycle after the strobe
    next_state.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        timer_channel_pkg::OFF_MODE:
          next_state.rdata = state.mode;
        timer_channel_pkg::OFF_COUNT:
          next_state.rdata = 32'(state.count);
        timer_channel_pkg::OFF_CMP_A:
          next_state.rdata = 32'(state.cmp_a);
        timer_channel_pkg::OFF_CMP_B:
          next_state.rdata = 32'(state.cmp_b);
        timer_channel_pkg::OFF_CMP_C:
          next_state.rdata = 32'(state.cmp_c);
        timer_channel_pkg::OFF_STATUS: begin
          next_state.rdata[timer_channel_pkg::STA_CLK_ENABLED] =
            state.clk_enabled;
          next_state.rdata[timer_channel_pkg::STA_LINE_A] = state.line_a;
          next_state.rdata[timer_channel_pkg::STA_LINE_B] =
            b_is_output ? state.line_b :
                          state.pin[timer_channel_pkg::PIN_LB];
        end
        timer_channel_pkg::OFF_PROTECT:
          next_state.rdata[timer_channel_pkg::PROT_ENABLE] = state.protect;
        default:
          next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata          = state.rdata;
  assign channel_line_a_out = state.line_a;
  assign channel_line_a_oe  = state.oe_a;
  assign channel_line_b_out = state.line_b;
  assign channel_line_b_oe  = state.oe_b;

endmodule
